// file: rtl/irs_ctrl.sv
// Interrupt request, status, in-service and mask block
//
// Our own choice: the Avalon-MM slave port.
module irs_ctrl (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire irs_pkg::irs_avs_req_t      bus_i,
    output irs_pkg::irs_avs_rsp_t           bus_o,
    input  wire irs_pkg::irs_src_t          src_i,
    input  wire logic [4:0]                 ext_req_i,
    input  wire logic                       nmi_i,
    input  wire logic [10:0][2:0]           prio_i,
    input  wire logic [3:0]                 svc_set_i,
    input  wire logic                       interrupt_return_i,
    output logic                            core_req_o,
    output logic                            core_nmi_o,
    output logic                            dma_hold_o,
    output logic [10:0]                     mask_o,
    output logic                            slave_o,
    output logic                            irq_o
);
    import irs_pkg::*;

    irs_state_t st;
    irs_state_t next_st;

    // ============================================================
    // Helper functions
    // ============================================================

    // Address match against a register index
    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [7:0]        idx
    );
        hit = (a == {idx, 2'b00});
    endfunction

    // Priority within threshold, 0 highest
    function automatic logic prio_ok(
        input logic [2:0] p,
        input logic [2:0] t
    );
        prio_ok = (p <= t);
    endfunction

    // ============================================================
    // Pin synchronisers
    // ============================================================
    logic [5:0] pin_sync;

    irs_sync #(
        .W (6)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({nmi_i, ext_req_i}),
        .q_o     (pin_sync)
    );

    logic [4:0] ext_s;
    logic       nmi_s;

    assign ext_s = pin_sync[4:0];
    assign nmi_s = pin_sync[5];

    // ============================================================
    // Live request vector
    // ============================================================
    logic [10:0] req_vec;
    logic        tmr_any;
    logic        ser_any;

    assign tmr_any = |src_i.timer;
    assign ser_any = src_i.ser_en & (|src_i.serial);

    always_comb begin
        req_vec              = '0;
        req_vec[B_TMR]       = tmr_any;
        req_vec[B_DMA0+1:B_DMA0] = src_i.dma;
        req_vec[B_EXT0+4:B_EXT0] = ext_s;
        req_vec[B_WD]        = src_i.wdog;
        req_vec[B_SER]       = ser_any;
    end

    // ============================================================
    // Gating toward the core
    // ============================================================
    logic [10:0] pass_vec;
    logic        pass_any;

    always_comb begin
        for (int i = 0; i < REQ_W; i++) begin
            pass_vec[i] = req_vec[i] & ~st.mask[i]
                & prio_ok(prio_i[i], st.thr);
        end
    end

    assign pass_any = |(pass_vec & REQ_VALID);

    // ============================================================
    // Bus decode
    // ============================================================
    logic        req_on;
    logic        wr_do;
    logic        rd_take;
    logic [15:0] wd16;

    assign req_on  = bus_i.read | bus_i.write;
    assign wr_do   = bus_i.write & st.ack;
    assign rd_take = req_on & ~st.ack;
    assign wd16    = bus_i.writedata[15:0];

    // ============================================================
    // Read data selection
    // ============================================================
    logic [15:0] rd_mux;
    logic [15:0] stat_word;

    always_comb begin
        stat_word         = '0;
        stat_word[B_HALT] = st.halt;
        stat_word[2:0]    = src_i.timer;
    end

    always_comb begin
        rd_mux = '0;
        if (hit(bus_i.address, IDX_MASK)) begin
            rd_mux = {5'h00, st.mask};
        end else if (hit(bus_i.address, IDX_PRIO)) begin
            rd_mux = {13'h0000, st.thr};
        end else if (hit(bus_i.address, IDX_INSVC)) begin
            rd_mux = {12'h000, st.insvc & INSVC_VALID};
        end else if (hit(bus_i.address, IDX_REQ)) begin
            rd_mux = {5'h00, req_vec};
        end else if (hit(bus_i.address, IDX_STAT)) begin
            rd_mux = stat_word;
        end else if (hit(bus_i.address, IDX_EVST)) begin
            rd_mux = {14'h0000, st.ev_st};
        end else if (hit(bus_i.address, IDX_EVEN)) begin
            rd_mux = {14'h0000, st.ev_en};
        end else if (hit(bus_i.address, IDX_RELOC)) begin
            rd_mux[B_SLAVE] = st.slave;
        end
    end

    // ============================================================
    // State update
    // ============================================================
    logic       nmi_rise;
    logic       pass_rise;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;

    assign nmi_rise  = nmi_s & ~st.nmi_d;
    assign pass_rise = pass_any & ~st.pass_d;

    always_comb begin
        ev_set         = '0;
        ev_set[EV_NMI] = nmi_rise;
        ev_set[EV_REQ] = pass_rise;
        ev_clr         = '0;
        if (wr_do && hit(bus_i.address, IDX_EVCLR)) begin
            ev_clr = wd16[EV_W-1:0];
        end
    end

    always_comb begin
        next_st = st;

        // Handshake: one wait cycle, answer on the next
        next_st.ack = rd_take;
        if (rd_take) begin
            next_st.rdata = rd_mux;
        end

        // Register writes
        if (wr_do) begin
            if (hit(bus_i.address, IDX_MASK)) begin
                next_st.mask = wd16[10:0] & REQ_VALID;
            end
            if (hit(bus_i.address, IDX_PRIO)) begin
                next_st.thr = wd16[2:0];
            end
            if (hit(bus_i.address, IDX_EVEN)) begin
                next_st.ev_en = wd16[EV_W-1:0];
            end
            if (hit(bus_i.address, IDX_RELOC)) begin
                next_st.slave = wd16[B_SLAVE];
            end
        end

        // DMA halt: set wins over the return
        if (interrupt_return_i) begin
            next_st.halt = 1'b0;
        end
        if (st.slave && nmi_rise) begin
            next_st.halt = 1'b1;
        end

        // In-service: set wins over the return
        if (interrupt_return_i) begin
            next_st.insvc = '0;
        end
        next_st.insvc = next_st.insvc
            | (svc_set_i & INSVC_VALID);

        // Sticky events: set wins over clear
        next_st.ev_st = (st.ev_st & ~ev_clr) | ev_set;

        next_st.nmi_d  = nmi_s;
        next_st.pass_d = pass_any;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st        <= '0;
            st.mask   <= MASK_RESET;
            st.thr    <= PRIO_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign bus_o = '{readdata: {16'h0000, st.rdata},
                     waitrequest: req_on & ~st.ack};

    assign core_req_o = st.pass_d;
    assign core_nmi_o = st.nmi_d;
    assign dma_hold_o = st.halt;
    assign mask_o     = st.mask;
    assign slave_o    = st.slave;
    assign irq_o      = |(st.ev_st & st.ev_en);

endmodule // irs_ctrl

// file: rtl/irs_pkg.sv
// Constants and types of the interrupt request, status and mask block
// ============================================================
// Contract
// - In slave mode a non-maskable interrupt sets the DMA-halt flag in bit 15, an interrupt return clears it, and while set DMA is held off.
// - The slave-mode status register shows timer 2, 1 and 0 requests in bits 2 to 0, with bits 14 to 3 reserved.
// - The timer summary request bit is the OR of the three timer request bits.
// - The pending request register is read-only, shows the live request lines and has no reset value of its own.
// - Request bit 10 is the serial port request, the OR of its six sources when the serial interrupt is enabled.
// - Request bit 9 reads one while a watchdog interrupt is pending.
// - Request bits 8 to 4 read one while external inputs 4 to 0 have a pending request.
// - Request bits 3 and 2 show DMA channel 1 and 0 requests, and bit 1 is reserved.
// - In-service bits 3 and 2 are one while DMA channel 1 or 0 is being serviced.
// - In-service bit 0 is one while the timer is being serviced, and bit 1 is reserved.
// - The priority threshold register resets to seven, holds the threshold in bits 2 to 0 and keeps its upper bits zero.
// - A maskable source whose priority is numerically above the threshold is blocked, so seven passes every unmasked source.
// - Priorities are three-bit binary, 0 highest and 7 lowest.
// - The mask register is read-write and drives the same mask bit that the per-source control registers use.
// - Relocation register bit 14 selects slave mode when one and master mode when zero.
// ============================================================
package irs_pkg;

    localparam int ADDR_W = 10;
    localparam int REQ_W  = 11;
    localparam int EV_W   = 2;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MASK  = 8'h28;
    localparam logic [7:0] IDX_PRIO  = 8'h2A;
    localparam logic [7:0] IDX_INSVC = 8'h2C;
    localparam logic [7:0] IDX_REQ   = 8'h2E;
    localparam logic [7:0] IDX_STAT  = 8'h30;
    localparam logic [7:0] IDX_EVST  = 8'hE8;
    localparam logic [7:0] IDX_EVCLR = 8'hEA;
    localparam logic [7:0] IDX_EVEN  = 8'hEC;
    localparam logic [7:0] IDX_RELOC = 8'hFE;

    // Field positions
    localparam int B_TMR   = 0;
    localparam int B_DMA0  = 2;
    localparam int B_EXT0  = 4;
    localparam int B_WD    = 9;
    localparam int B_SER   = 10;
    localparam int B_SLAVE = 14;
    localparam int B_HALT  = 15;
    localparam int EV_NMI  = 0;
    localparam int EV_REQ  = 1;

    // Reset values and valid-bit masks
    localparam logic [2:0]  PRIO_RESET  = 3'h7;
    localparam logic [10:0] MASK_RESET  = 11'h000;
    localparam logic [10:0] REQ_VALID   = 11'h7FD;
    localparam logic [3:0]  INSVC_VALID = 4'hD;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
    } irs_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } irs_avs_rsp_t;

    // Sources on the block's own clock
    typedef struct packed {
        logic [2:0] timer;
        logic [1:0] dma;
        logic       wdog;
        logic [5:0] serial;
        logic       ser_en;
    } irs_src_t;

    typedef struct packed {
        logic [10:0]    mask;
        logic [2:0]     thr;
        logic           halt;
        logic [3:0]     insvc;
        logic           slave;
        logic [EV_W-1:0] ev_st;
        logic [EV_W-1:0] ev_en;
        logic           ack;
        logic [15:0]    rdata;
        logic           nmi_d;
        logic           pass_d;
    } irs_state_t;

endpackage

// file: rtl/irs_sync.sv
// Two-flop synchroniser for pin inputs
module irs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule // irs_sync

// file: tb/irs_core_model.sv
// Processor core model: services requests and returns
module irs_core_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       en_i,
    input  wire logic       slow_i,
    input  wire logic       ret_i,
    input  wire logic [3:0] bits_i,
    input  wire logic       req_i,
    input  wire logic       nmi_i,
    output logic      [3:0] svc_set_o,
    output logic            interrupt_return_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       busy;
    logic [2:0] cnt;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy      <= 1'b0;
            cnt       <= 3'h0;
            svc_set_o <= 4'h0;
            interrupt_return_o    <= 1'b0;
        end else begin
            svc_set_o <= 4'h0;
            interrupt_return_o    <= 1'b0;
            if (!busy && en_i && (req_i || nmi_i)) begin
                // Slow answer waits four extra cycles
                if (cnt == (slow_i ? 3'h4 : 3'h0)) begin
                    svc_set_o <= bits_i;
                    busy      <= 1'b1;
                    cnt       <= 3'h0;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end else if (busy && ret_i) begin
                interrupt_return_o <= 1'b1;
                busy   <= 1'b0;
            end
        end
    end
endmodule // irs_core_model

// file: tb/irs_ctrl_checker.sv
// Concurrent checks on the ports of the interrupt block
module irs_ctrl_checker import irs_pkg::*; (
    input wire logic         clk_i,
    input wire logic         rst_n_i,
    input wire irs_avs_req_t bus_i,
    input wire irs_avs_rsp_t bus_o,
    input wire logic         nmi_i,
    input wire logic         interrupt_return_i,
    input wire logic         core_req_o,
    input wire logic         core_nmi_o,
    input wire logic         dma_hold_o,
    input wire logic [10:0]  mask_o,
    input wire logic         slave_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_nmi_halt;
        $rose(core_nmi_o) && slave_o |-> ##[0:1] dma_hold_o;
    endproperty
    a_nmi_halt: assert property (p_nmi_halt)
        else $error("halt not set by nmi");
    property p_interrupt_return_clr;
        (!nmi_i)[*3] ##0 interrupt_return_i |=> !dma_hold_o;
    endproperty
    a_interrupt_return_clr: assert property (p_interrupt_return_clr)
        else $error("halt not cleared by return");
    property p_fall_interrupt_return;
        $fell(dma_hold_o) |-> $past(interrupt_return_i);
    endproperty
    a_fall_interrupt_return: assert property (p_fall_interrupt_return)
        else $error("halt cleared without return");
    property p_halt_slave;
        $rose(dma_hold_o) |-> $past(slave_o);
    endproperty
    a_halt_slave: assert property (p_halt_slave)
        else $error("halt set in master mode");
    property p_all_masked;
        (mask_o == 11'h7FD)[*3] |-> !core_req_o;
    endproperty
    a_all_masked: assert property (p_all_masked)
        else $error("request passed full mask");
    property p_mask_wr;
        !$stable(mask_o) |-> $past(bus_i.write);
    endproperty
    a_mask_wr: assert property (p_mask_wr)
        else $error("mask changed without write");
    property p_slave_wr;
        !$stable(slave_o) |-> $past(bus_i.write);
    endproperty
    a_slave_wr: assert property (p_slave_wr)
        else $error("mode changed without write");
    property p_mask_rsv;
        mask_o[1] == 1'b0;
    endproperty
    a_mask_rsv: assert property (p_mask_rsv)
        else $error("reserved mask bit set");
    property p_one_wait;
        (bus_i.read || bus_i.write) && bus_o.waitrequest
            |=> !bus_o.waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer late");
    property p_rst_val;
        !$past(rst_n_i) |-> mask_o == 11'h000 && !slave_o && !dma_hold_o;
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("bad value after reset");
    c_halt: cover property (dma_hold_o ##1 !dma_hold_o);
    c_req: cover property ($rose(core_req_o));
    c_read: cover property (bus_i.read && !bus_o.waitrequest);
endmodule // irs_ctrl_checker

bind irs_ctrl irs_ctrl_checker i_irs_ctrl_checker (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .bus_o(bus_o),
    .nmi_i(nmi_i), .interrupt_return_i(interrupt_return_i), .core_req_o(core_req_o),
    .core_nmi_o(core_nmi_o), .dma_hold_o(dma_hold_o),
    .mask_o(mask_o), .slave_o(slave_o));

// file: tb/tb_irs_ctrl.sv
// Self-checking testbench of the interrupt request and mask block
module tb_irs_ctrl import irs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk_i = 1'b0;
    logic             rst_n_i = 1'b0;
    irs_avs_req_t     bus;
    irs_avs_rsp_t     rsp;
    irs_src_t         src;
    logic [4:0]       ext;
    logic [10:0][2:0] prio;
    logic [3:0]       svc, bits;
    logic [10:0]      mask;
    logic [15:0]      rd;
    logic [2:0]       p;
    logic             nmi, interrupt_return, en, slow, ret, creq, cnmi, hold, slave, irq;
    int               errors = 0;
    int               check_count = 0;

    always #4 clk_i = ~clk_i;

    irs_ctrl i_irs_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus),
        .bus_o(rsp), .src_i(src), .ext_req_i(ext), .nmi_i(nmi),
        .prio_i(prio), .svc_set_i(svc), .interrupt_return_i(interrupt_return), .core_req_o(creq),
        .core_nmi_o(cnmi), .dma_hold_o(hold), .mask_o(mask),
        .slave_o(slave), .irq_o(irq));
    irs_core_model i_irs_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .en_i(en), .slow_i(slow), .ret_i(ret), .bits_i(bits), .req_i(creq),
        .nmi_i(cnmi), .svc_set_o(svc), .interrupt_return_o(interrupt_return));

    // ============================================================
    // Tasks
    function automatic logic [15:0] exp_req(irs_src_t s, logic [4:0] e);
        return {5'h00, s.ser_en & |s.serial, s.wdog, e, s.dma, 1'b0, |s.timer};
    endfunction
    task automatic check(logic [15:0] got, logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(logic w, logic [9:0] a, logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        bus <= {~w, w, a, 16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.waitrequest && n < 20);
        if (n >= 20) errors++;
        rd = rsp.readdata[15:0];
        bus <= '0;
    endtask
    task automatic rdc(logic [9:0] a, logic [15:0] exp);
        acc(1'b0, a, 16'h0000);
        check(rd, exp);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        tick(20000);
        errors++;
        summarize();
    end

    // ============================================================
    // Tests
    initial begin
        {bus, src, ext, prio, nmi, en, slow, ret, bits} = '0;
        void'($urandom(32'h198A));
        tick(12);
        rst_n_i <= 1'b1;
        rdc(10'h0A8, 16'h0007);
        rdc(10'h0A0, 16'h0000);
        rdc(10'h3F8, 16'h0000);
        rdc(10'h004, 16'h0000);
        acc(1'b1, 10'h0A8, 16'hFFFA);
        rdc(10'h0A8, 16'h0002);
        acc(1'b1, 10'h0A0, 16'hFFFF);
        rdc(10'h0A0, 16'h07FD);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_i);
            if (i < 2) {src, ext} <= {18{i[0]}};
            else {src, ext} <= 18'($urandom);
            tick(3);
            rdc(10'h0B8, exp_req(src, ext));
        end
        acc(1'b1, 10'h0B8, 16'hFFFF);
        rdc(10'h0B8, exp_req(src, ext));
        src <= 13'h0400;
        ext <= 5'h00;
        tick(4);
        check(creq, 1'b0);
        acc(1'b1, 10'h0A0, 16'h0000);
        for (int t = 0; t < 8; t++) begin
            p = t[0] ? t[2:0] : 3'($urandom);
            prio <= {11{p}};
            acc(1'b1, 10'h0A8, 16'(t));
            tick(3);
            check(creq, p <= t);
        end
        acc(1'b1, 10'h0A0, 16'h0001);
        tick(3);
        check(creq, 1'b0);
        $display("test requests done");
        acc(1'b1, 10'h3F8, 16'h4000);
        src <= 13'h1400;
        nmi <= 1'b1;
        tick(5);
        check(slave, 1'b1);
        check(hold, 1'b1);
        check(cnmi, 1'b1);
        rdc(10'h0C0, 16'h8005);
        en <= 1'b1;
        bits <= 4'hF;
        slow <= 1'($urandom);
        tick(8);
        rdc(10'h0B0, 16'h000D);
        {en, nmi} <= 2'b00;
        tick(3);
        ret <= 1'b1;
        tick(1);
        ret <= 1'b0;
        tick(3);
        check(hold, 1'b0);
        rdc(10'h0B0, 16'h0000);
        $display("test halt done");
        acc(1'b1, 10'h3F8, 16'h0000);
        acc(1'b1, 10'h3A8, 16'h0003);
        acc(1'b1, 10'h3B0, 16'h0001);
        tick(1);
        check(irq, 1'b0);
        nmi <= 1'b1;
        tick(5);
        check(hold, 1'b0);
        check(irq, 1'b1);
        rdc(10'h3A0, 16'h0001);
        acc(1'b1, 10'h3B0, 16'h0000);
        tick(1);
        check(irq, 1'b0);
        acc(1'b1, 10'h3B0, 16'h0001);
        tick(1);
        check(irq, 1'b1);
        acc(1'b1, 10'h3A8, 16'h0001);
        tick(1);
        check(irq, 1'b0);
        $display("test events done");
        acc(1'b1, 10'h0A8, 16'h0003);
        rst_n_i <= 1'b0;
        tick(2);
        rst_n_i <= 1'b1;
        rdc(10'h0A8, 16'h0007);
        $display("test reset done");
        summarize();
    end
endmodule // tb_irs_ctrl
